// File: hdl/fps_cfg.svh
// constants of the flash protection and security control block
//
// Summary of operation
// [RULE1] each reset copies the nonvolatile option byte into the option shadow register
// [RULE2] option shadow reads zero in bits 5..2; writes to it change nothing
// [RULE3] software changes option value by reprogramming the byte, then resetting again
// [RULE4] with backdoor enable bit 7 clear, the key never unsecures the part
// [RULE5] enabled key plus eight matching in-order bytes from secure code unsecures until reset
// [RULE6] key bytes written by background debug are never taken as key writes
// [RULE7] option bit 6 high disables vector redirection; low keeps it enabled
// [RULE8] security code 1:0 alone means unsecured; 0:0, 0:1, 1:1 mean secure
// [RULE9] software should use code 0:1, two bit flips away from unsecured
// [RULE10] while secure, memory access from unsecured sources, debug included, is blocked
// [RULE11] config bits 7..5 read and write freely; bits 4..0 read zero
// [RULE12] key window writes start a flash command, or with steer set load key bytes
// [RULE13] reset sequence loads protection register from the nonvolatile protection byte
// [RULE14] software changes reset protection by unprotecting, erasing, reprogramming that byte
// [RULE15] with protection disable set, every protection register bit is writable
// [RULE16] with protection on, protect select writes only enlarge the protected region
// [RULE17] protect select bits 7..1 give end of unprotected area; top end protected
// [RULE18] protection bit 0 low enables block protection, high protects nothing
// [RULE19] program or erase into a protected area is refused and sets the violation flag
// [RULE20] mass erase is refused while any sector is protected
// [RULE21] background debug may change protect select bits in any mode
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH

`define FPS_ADDR_OPT     16'h1820
`define FPS_ADDR_CFG     16'h1821
`define FPS_ADDR_PROT    16'h1822
`define FPS_ADDR_STAT    16'h1823
`define FPS_KEY_LO       16'hFFB0
`define FPS_KEY_HI       16'hFFB7

`define FPS_OPT_BACKDOOR_ENABLE    7
`define FPS_OPT_NORED    6
`define FPS_OPT_MASK     8'hC3
`define FPS_SEC_UNSEC    2'h2
`define FPS_CFG_MASK     8'hE0
`define FPS_CFG_STEER    5
`define FPS_PROT_DIS     0
`define FPS_FPS_NONE     7'h7F
`define FPS_STAT_VIOL    5
`define FPS_STAT_SEC     0
`define FPS_KEY_BYTES    4'h8
`define FPS_RST_CFG      8'h00
`define FPS_RST_PROT     8'hFF
`define FPS_RST_OPT      8'h00

`endif

// File: hdl/fps_pkg.sv
// types shared by the flash protection and security control block
package fps_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        from_bdm;
    logic        from_secure;
  } fps_bus_req_t;

  typedef struct packed {
    logic        req;
    logic [15:0] addr;
    logic        mass;
  } fps_cmd_req_t;

  typedef enum logic [1:0] {
    FPS_ST_LOAD = 2'b01,
    FPS_ST_RUN  = 2'b10
  } fps_state_t;

endpackage

// File: hdl/fps_key_cmp.sv
// backdoor key sequence tracker: eight in-order matching bytes
`timescale 1ns/1ps
`default_nettype none
`include "fps_cfg.svh"
module fps_key_cmp
  import fps_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // key write stream
  input  wire logic        clear,
  input  wire logic        key_wr,
  input  wire logic [2:0]  key_idx,
  input  wire logic [7:0]  key_byte,
  input  wire logic [63:0] key_ref,
  // result
  output logic             key_ok
);

  logic [3:0] cnt_reg;
  logic       match_reg;
  logic       eq;

  function automatic logic [7:0] ref_byte(input logic [63:0] k, input logic [2:0] i);
    ref_byte = k[{i, 3'h0} +: 8];
  endfunction

  assign eq = (key_byte == ref_byte(key_ref, key_idx));

  // sequence restarts at the first window byte; any out-of-order byte spoils it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg   <= 4'h0;
      match_reg <= 1'b0;
    end else if (clear) begin
      cnt_reg   <= 4'h0;
      match_reg <= 1'b0;
    end else if (key_wr) begin
      if (key_idx == 3'h0) begin
        cnt_reg   <= 4'h1;
        match_reg <= eq;
      end else if (cnt_reg != 4'h0 && {1'b0, key_idx} == cnt_reg) begin
        cnt_reg   <= cnt_reg + 4'h1;
        match_reg <= match_reg & eq;
      end else begin
        cnt_reg   <= 4'h0;
        match_reg <= 1'b0;
      end
    end
  end

  assign key_ok = match_reg && (cnt_reg == `FPS_KEY_BYTES); // [RULE5]

endmodule // fps_key_cmp
`default_nettype wire

// File: hdl/fps_top.sv
// flash option, configuration, security and block protection control
`timescale 1ns/1ps
`default_nettype none
`include "fps_cfg.svh"
module fps_top
  import fps_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // register port
  input  wire fps_bus_req_t bus,
  output logic [7:0]       rd_data,
  // nonvolatile images from the flash array
  input  wire logic [7:0]  nv_option_byte,
  input  wire logic [7:0]  nv_protection_byte,
  input  wire logic [63:0] nv_backdoor_key,
  // key window writes passed to the command engine
  output logic             kw_cmd_start,
  output logic [15:0]      kw_cmd_addr,
  output logic [7:0]       kw_cmd_data,
  // program and erase check
  input  wire fps_cmd_req_t cmd,
  output logic             cmd_accept,
  output logic             cmd_refuse,
  // memory access gate
  input  wire logic        mem_req,
  input  wire logic        mem_from_unsecured,
  output logic             mem_grant,
  // status levels
  output logic             secure,
  output logic             vector_redirect_en,
  output logic             protection_violation_flag
);

  fps_state_t  state_reg;
  logic [7:0]  option_shadow_reg;
  logic [7:0]  config_reg;
  logic [7:0]  protection_reg;
  logic        secure_reg;
  logic        viol_reg;
  logic [7:0]  rd_data_reg;
  logic        kw_start_reg;
  logic [15:0] kw_addr_reg;
  logic [7:0]  kw_data_reg;
  logic        accept_reg;
  logic        refuse_reg;

  logic        run;
  logic        backdoor_enable;
  logic        key_write_steer;
  logic        protection_disable;
  logic [6:0]  protect_select;
  logic        win_wr;
  logic        key_wr;
  logic        key_ok;
  logic        steer_clear;
  logic        prot_wr;
  logic        any_protected;
  logic        cmd_hit;

  function automatic logic in_key_window(input logic [15:0] a);
    in_key_window = (a >= `FPS_KEY_LO) && (a <= `FPS_KEY_HI);
  endfunction

  // protected area sits above the end of the unprotected area
  function automatic logic prot_hit(input logic [15:0] a, input logic [7:0] p);
    prot_hit = !p[`FPS_PROT_DIS] && (a[15:9] > p[7:1]);
  endfunction

  assign run                = (state_reg == FPS_ST_RUN);
  assign backdoor_enable    = option_shadow_reg[`FPS_OPT_BACKDOOR_ENABLE];
  assign key_write_steer    = config_reg[`FPS_CFG_STEER];
  assign protection_disable = protection_reg[`FPS_PROT_DIS];
  assign protect_select     = protection_reg[7:1];

  // state: one load cycle after reset release, then run
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= FPS_ST_LOAD;
    end else begin
      case (state_reg)
        FPS_ST_LOAD: state_reg <= FPS_ST_RUN;
        FPS_ST_RUN:  state_reg <= FPS_ST_RUN;
        default:     state_reg <= FPS_ST_LOAD;
      endcase
    end
  end

  // option shadow: loaded once per reset, never written by the bus
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      option_shadow_reg <= `FPS_RST_OPT;
    end else if (state_reg == FPS_ST_LOAD) begin
      option_shadow_reg <= nv_option_byte & `FPS_OPT_MASK; // [RULE1] [RULE2]
    end
  end

  // configuration: upper three bits only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      config_reg <= `FPS_RST_CFG;
    end else if (run && bus.wr && bus.addr == `FPS_ADDR_CFG) begin
      config_reg <= bus.wdata & `FPS_CFG_MASK; // [RULE11]
    end
  end

  // key window steering
  assign win_wr = run && bus.wr && in_key_window(bus.addr);
  assign key_wr = win_wr && key_write_steer && !bus.from_bdm && bus.from_secure; // [RULE6] [RULE12]
  assign steer_clear = run && bus.wr && bus.addr == `FPS_ADDR_CFG && key_write_steer
                       && !bus.wdata[`FPS_CFG_STEER];

  fps_key_cmp u_key (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .clear    (steer_clear || !run),
    .key_wr   (key_wr),
    .key_idx  (bus.addr[2:0]),
    .key_byte (bus.wdata),
    .key_ref  (nv_backdoor_key),
    .key_ok   (key_ok)
  );

  // security state: decoded at load, left only by a good backdoor key
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      secure_reg <= 1'b1;
    end else if (state_reg == FPS_ST_LOAD) begin
      secure_reg <= (nv_option_byte[1:0] != `FPS_SEC_UNSEC); // [RULE8]
    end else if (steer_clear && !bus.from_bdm && bus.from_secure
                 && backdoor_enable && key_ok) begin
      secure_reg <= 1'b0; // [RULE4] [RULE5]
    end
  end

  // window writes with steer clear start a flash command
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      kw_start_reg <= 1'b0;
      kw_addr_reg  <= 16'h0000;
      kw_data_reg  <= 8'h00;
    end else begin
      kw_start_reg <= win_wr && !key_write_steer; // [RULE12]
      if (win_wr && !key_write_steer) begin
        kw_addr_reg <= bus.addr;
        kw_data_reg <= bus.wdata;
      end
    end
  end

  // protection register
  assign prot_wr = run && bus.wr && bus.addr == `FPS_ADDR_PROT;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      protection_reg <= `FPS_RST_PROT;
    end else if (state_reg == FPS_ST_LOAD) begin
      protection_reg <= nv_protection_byte; // [RULE13]
    end else if (prot_wr) begin
      if (bus.from_bdm) begin
        protection_reg <= bus.wdata; // [RULE21]
      end else if (protection_disable) begin
        protection_reg <= bus.wdata; // [RULE15]
      end else if (bus.wdata[7:1] < protect_select) begin
        protection_reg <= {bus.wdata[7:1], 1'b0}; // [RULE16]
      end
    end
  end

  // program and erase check
  assign any_protected = !protection_disable && (protect_select != `FPS_FPS_NONE); // [RULE18]
  assign cmd_hit = cmd.mass ? any_protected : prot_hit(cmd.addr, protection_reg); // [RULE17] [RULE20]

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      accept_reg <= 1'b0;
      refuse_reg <= 1'b0;
    end else begin
      accept_reg <= run && cmd.req && !cmd_hit;
      refuse_reg <= run && cmd.req && cmd_hit; // [RULE19] [RULE20]
    end
  end

  // violation flag: set wins over a write-one clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      viol_reg <= 1'b0;
    end else if (run && cmd.req && cmd_hit) begin
      viol_reg <= 1'b1; // [RULE19]
    end else if (run && bus.wr && bus.addr == `FPS_ADDR_STAT && bus.wdata[`FPS_STAT_VIOL]) begin
      viol_reg <= 1'b0;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        `FPS_ADDR_OPT:  rd_data_reg <= option_shadow_reg; // [RULE2]
        `FPS_ADDR_CFG:  rd_data_reg <= config_reg; // [RULE11]
        `FPS_ADDR_PROT: rd_data_reg <= protection_reg;
        `FPS_ADDR_STAT: rd_data_reg <= {2'h0, viol_reg, 4'h0, secure_reg};
        default:        rd_data_reg <= 8'h00;
      endcase
    end else begin
      rd_data_reg <= 8'h00;
    end
  end

  // outputs
  assign rd_data                   = rd_data_reg;
  assign kw_cmd_start              = kw_start_reg;
  assign kw_cmd_addr               = kw_addr_reg;
  assign kw_cmd_data               = kw_data_reg;
  assign cmd_accept                = accept_reg;
  assign cmd_refuse                = refuse_reg;
  assign secure                    = secure_reg;
  assign protection_violation_flag = viol_reg;
  assign vector_redirect_en        = !option_shadow_reg[`FPS_OPT_NORED]; // [RULE7]
  assign mem_grant = mem_req && !(secure_reg && mem_from_unsecured); // [RULE10]

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_load;
    state_reg == FPS_ST_LOAD;
  endsequence

  sequence s_good_unlock;
    steer_clear && !bus.from_bdm && bus.from_secure && backdoor_enable && key_ok;
  endsequence

  a_opt_load_image: assert property (s_load |=> // [RULE1]
      option_shadow_reg == ($past(nv_option_byte) & `FPS_OPT_MASK))
    else $error("option shadow not loaded from nonvolatile byte");

  a_opt_write_ignored: assert property ( // [RULE2]
      (run && bus.wr && bus.addr == `FPS_ADDR_OPT) |=> $stable(option_shadow_reg)
                                                       && option_shadow_reg[5:2] == 4'h0)
    else $error("option shadow changed by a write");

  a_key_disabled: assert property ( // [RULE4]
      (run && secure_reg && !backdoor_enable) |=> secure_reg)
    else $error("left secure state with backdoor disabled");

  a_key_unlock: assert property (s_good_unlock |=> !secure_reg ##1 !secure_reg) // [RULE5]
    else $error("good key did not unsecure");

  a_bdm_key_block: assert property ( // [RULE6]
      (win_wr && bus.from_bdm && !key_ok) |=> !key_ok)
    else $error("debug write advanced the key sequence");

  a_redirect_bit: assert property ( // [RULE7]
      vector_redirect_en == !option_shadow_reg[`FPS_OPT_NORED])
    else $error("vector redirect does not follow option bit");

  a_sec_decode: assert property (s_load |=> // [RULE8]
      secure_reg == ($past(nv_option_byte[1:0]) != 2'h2))
    else $error("security code decoded wrongly");

  a_mem_block: assert property ( // [RULE10]
      (secure_reg && mem_from_unsecured) |-> !mem_grant)
    else $error("unsecured access granted while secure");

  a_cfg_low_zero: assert property (config_reg[4:0] == 5'h00) // [RULE11]
    else $error("config low bits not zero");

  a_kw_cmd_start: assert property ( // [RULE12]
      (win_wr && !key_write_steer) |=> kw_cmd_start && kw_cmd_addr == $past(bus.addr))
    else $error("key window write did not start a command");

  a_prot_no_shrink: assert property ( // [RULE16]
      (prot_wr && !bus.from_bdm && !protection_disable && bus.wdata[7:1] >= protect_select)
      |=> $stable(protection_reg))
    else $error("protected region shrank");

  a_prot_violation: assert property ( // [RULE19]
      (run && cmd.req && !cmd.mass && prot_hit(cmd.addr, protection_reg))
      |=> cmd_refuse && !cmd_accept && protection_violation_flag)
    else $error("protected program or erase not refused");

  a_mass_block: assert property ( // [RULE20]
      (run && cmd.req && cmd.mass && any_protected) |=> cmd_refuse)
    else $error("mass erase allowed with protection");

  sequence s_user_prot_wr;
    prot_wr && !bus.from_bdm;
  endsequence

  a_prot_load_image: assert property ( // [RULE13]
      s_load
      |=> protection_reg == $past(nv_protection_byte))
    else $error("protection not loaded from nonvolatile byte");

  a_prot_dis_write: assert property ( // [RULE15]
      (s_user_prot_wr and protection_disable)
      |=> protection_reg == $past(bus.wdata))
    else $error("write with protection disabled not taken");

  a_prot_grow: assert property ( // [RULE16]
      (s_user_prot_wr and (!protection_disable && bus.wdata[7:1] < protect_select))
      |=> protection_reg == {$past(bus.wdata[7:1]), 1'b0})
    else $error("enlarging protection write not taken");

  a_prot_range: assert property ( // [RULE17]
      (run && cmd.req && !cmd.mass && !protection_disable && cmd.addr[15:9] <= protect_select)
      |=> cmd_accept && !cmd_refuse)
    else $error("unprotected address refused");

  a_prot_off: assert property ( // [RULE18]
      (run && cmd.req && protection_disable)
      |=> cmd_accept && !cmd_refuse)
    else $error("command refused with protection disabled");

  a_mass_allowed: assert property ( // [RULE20]
      (run && cmd.req && cmd.mass && !any_protected)
      |=> cmd_accept)
    else $error("mass erase refused without protection");

  a_bdm_prot_write: assert property ( // [RULE21]
      (prot_wr && bus.from_bdm)
      |=> protection_reg == $past(bus.wdata))
    else $error("debug protection write not taken");

  a_viol_sticky: assert property ( // [RULE19]
      (viol_reg && !(bus.wr && bus.addr == `FPS_ADDR_STAT && bus.wdata[`FPS_STAT_VIOL]))
      |=> viol_reg)
    else $error("violation flag dropped without a clear");

  a_cfg_write: assert property ( // [RULE11]
      (run && bus.wr && bus.addr == `FPS_ADDR_CFG)
      |=> config_reg == ($past(bus.wdata) & `FPS_CFG_MASK))
    else $error("config write not taken");

  a_kw_steer_off: assert property ( // [RULE12]
      (win_wr && key_write_steer)
      |=> !kw_cmd_start)
    else $error("steered key write started a command");

  a_opt_hold: assert property ( // [RULE2]
      run
      |=> $stable(option_shadow_reg))
    else $error("option shadow changed while running");

endmodule // fps_top
`default_nettype wire

// File: verification/fps_host_model.sv
// register port master model standing for the cpu or the debug host
`timescale 1ns/1ps
`default_nettype none
module fps_host_model
  import fps_pkg::*;
(
  // clock
  input  wire logic       ref_clk,
  // register port
  output var fps_bus_req_t bus,
  input  wire logic [7:0] rd_data
);
  initial bus = '0;

  // one-cycle write strobe beside address, data and source
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic background_debug_mode,
                    input logic sec);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, from_bdm: background_debug_mode, from_secure: sec};
    @(posedge ref_clk);
    bus <= '0;
  endtask

  // one-cycle read strobe; data stand only in the following cycle
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, from_bdm: 1'b0, from_secure: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1;
    d = rd_data;
  endtask
endmodule // fps_host_model
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench of the flash protection and security block
`timescale 1ns/1ps
`default_nettype none
`include "fps_cfg.svh"
module testbench
  import fps_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         rst_b = 1'b0;
  fps_bus_req_t bus;
  logic [7:0]   rd_data;
  logic [7:0]   nv_opt = 8'h00;
  logic [7:0]   nv_prot = 8'hFF;
  logic [63:0]  key = 64'h0123_4567_89AB_CDEF;
  fps_cmd_req_t cmd = '0;
  logic         mem_req = 1'b0;
  logic         mem_unsec = 1'b0;
  logic         mem_grant;
  logic         kw_start;
  logic [15:0]  kw_addr;
  logic [7:0]   kw_data;
  logic         acc;
  logic         refuse;
  logic         secure;
  logic         vre;
  logic         viol;
  int           num_errors = 0;
  int           checks = 0;

  always #25 ref_clk = ~ref_clk;

  fps_host_model fps_host_model_inst (.ref_clk(ref_clk), .bus(bus), .rd_data(rd_data));

  fps_top fps_top_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .rd_data(rd_data),
    .nv_option_byte(nv_opt), .nv_protection_byte(nv_prot), .nv_backdoor_key(key),
    .kw_cmd_start(kw_start), .kw_cmd_addr(kw_addr), .kw_cmd_data(kw_data),
    .cmd(cmd), .cmd_accept(acc), .cmd_refuse(refuse),
    .mem_req(mem_req), .mem_from_unsecured(mem_unsec), .mem_grant(mem_grant),
    .secure(secure), .vector_redirect_en(vre), .protection_violation_flag(viol)
  );

  task automatic test_done();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    fps_host_model_inst.rd(a, d);
    chk(16'(d), 16'(exp), what);
  endtask

  task automatic do_reset(input logic [7:0] opt, input logic [7:0] prot);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    nv_opt <= opt;
    nv_prot <= prot;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic do_cmd(input logic [15:0] a, input logic m, input logic no, input string what);
    @(posedge ref_clk);
    cmd <= '{req: 1'b1, addr: a, mass: m};
    @(posedge ref_clk);
    cmd <= '0;
    #1;
    chk(16'(refuse), 16'(no), what);
    chk(16'(acc), 16'(!no), what);
  endtask

  task automatic mem_chk(input logic unsec, input logic exp);
    @(posedge ref_clk);
    mem_req <= 1'b1;
    mem_unsec <= unsec;
    #1;
    chk(16'(mem_grant), 16'(exp), "memory gate");
  endtask

  // steer on, eight key bytes in address order, steer off
  task automatic key_seq(input logic background_debug_mode);
    fps_host_model_inst.wr(`FPS_ADDR_CFG, 8'h20, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      fps_host_model_inst.wr(`FPS_KEY_LO | 16'(i), key[8*i +: 8], background_debug_mode, 1'b1);
    end
    fps_host_model_inst.wr(`FPS_ADDR_CFG, 8'h00, 1'b0, 1'b1);
    @(posedge ref_clk);
    #1;
  endtask

  task automatic t_sec_codes();
    for (int c = 0; c < 4; c++) begin
      do_reset({2'b01, 4'hF, 2'(c)}, 8'hFF);
      rchk(`FPS_ADDR_OPT, {2'b01, 4'h0, 2'(c)}, "option load");
      chk(16'(secure), 16'(c != 2), "security decode");
      chk(16'(vre), 16'h0, "redirect disabled");
    end
  endtask

  task automatic t_option();
    do_reset(8'hBD, 8'hFF);
    fps_host_model_inst.wr(`FPS_ADDR_OPT, 8'hFF, 1'b0, 1'b1);
    rchk(`FPS_ADDR_OPT, 8'h81, "option write");
    chk(16'(vre), 16'h1, "redirect enabled");
    mem_chk(1'b1, 1'b0);
    mem_chk(1'b0, 1'b1);
  endtask

  task automatic t_config();
    fps_host_model_inst.wr(`FPS_ADDR_CFG, 8'hFF, 1'b0, 1'b1);
    rchk(`FPS_ADDR_CFG, 8'hE0, "config bits");
    fps_host_model_inst.wr(`FPS_KEY_LO | 16'h3, 8'h5A, 1'b0, 1'b1);
    #1;
    chk(16'(kw_start), 16'h0, "steered key write");
    fps_host_model_inst.wr(`FPS_ADDR_CFG, 8'h00, 1'b0, 1'b1);
    fps_host_model_inst.wr(`FPS_KEY_LO | 16'h3, 8'h5A, 1'b1, 1'b0);
    #1;
    chk(16'(kw_start), 16'h1, "command start");
    chk(kw_addr, 16'hFFB3, "command address");
    chk(16'(kw_data), 16'h5A, "command data");
  endtask

  task automatic t_key();
    key_seq(1'b1);
    chk(16'(secure), 16'h1, "debug key");
    key_seq(1'b0);
    chk(16'(secure), 16'h0, "firmware key");
    mem_chk(1'b1, 1'b1);
    do_reset(8'h01, 8'hFF);
    key_seq(1'b0);
    chk(16'(secure), 16'h1, "key disabled");
  endtask

  task automatic t_prot();
    do_reset(8'h81, 8'h80);
    rchk(`FPS_ADDR_PROT, 8'h80, "protection load");
    fps_host_model_inst.wr(`FPS_ADDR_PROT, 8'hA0, 1'b0, 1'b1);
    rchk(`FPS_ADDR_PROT, 8'h80, "shrink ignored");
    fps_host_model_inst.wr(`FPS_ADDR_PROT, 8'h60, 1'b0, 1'b1);
    rchk(`FPS_ADDR_PROT, 8'h60, "grow taken");
    do_cmd(16'h6200, 1'b0, 1'b1, "protected program");
    chk(16'(viol), 16'h1, "violation flag");
    do_cmd(16'h6000, 1'b0, 1'b0, "unprotected program");
    do_cmd(16'h0000, 1'b1, 1'b1, "mass erase");
    rchk(`FPS_ADDR_STAT, 8'h21, "status");
    fps_host_model_inst.wr(`FPS_ADDR_STAT, 8'h20, 1'b0, 1'b1);
    rchk(`FPS_ADDR_STAT, 8'h01, "flag cleared");
    fps_host_model_inst.wr(`FPS_ADDR_PROT, 8'h61, 1'b0, 1'b1);
    rchk(`FPS_ADDR_PROT, 8'h60, "disable refused");
    fps_host_model_inst.wr(`FPS_ADDR_PROT, 8'hFF, 1'b1, 1'b0);
    rchk(`FPS_ADDR_PROT, 8'hFF, "debug write");
    do_cmd(16'h0000, 1'b1, 1'b0, "mass unprotected");
    do_cmd(16'hFE00, 1'b0, 1'b0, "top unprotected");
    fps_host_model_inst.wr(`FPS_ADDR_PROT, 8'h41, 1'b0, 1'b1);
    rchk(`FPS_ADDR_PROT, 8'h41, "disabled write");
    rchk(16'h1830, 8'h00, "unmapped read");
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("[FAIL] %0t run limit reached", $time);
    test_done();
  end

  initial begin
    t_sec_codes();
    t_option();
    t_config();
    t_key();
    t_prot();
    test_done();
  end
endmodule // testbench
`default_nettype wire
